// ==== lcpc_pkg.sv ====
package lcpc_pkg;
    localparam int NUM_CH   = 6;
    localparam int PERIOD_W = 20;
    localparam int STEP_W   = 7;

    localparam logic [7:0] ADDR_CFG   = 8'h08;
    localparam logic [7:0] ADDR_CHAN  = 8'h09;
    localparam logic [7:0] ADDR_PHASE = 8'h0A;

    localparam logic [7:0] RST_CFG   = 8'h1F;
    localparam logic [5:0] RST_CHAN  = 6'h3F;
    localparam logic [7:0] RST_PHASE = 8'h00;

    localparam int CFG_DIRECT_BIT = 6;
    localparam int CFG_DC_BIT     = 5;
    localparam int CFG_DRV_LSB    = 3;
    localparam int CFG_FSW_BIT    = 2;
    localparam int CFG_VSC_LSB    = 0;
    localparam int PH_EQUAL_BIT   = 7;

    localparam longint CLK_HZ   = 50_000_000;
    localparam longint REF_HZ   = 12_800_000;
    localparam longint STEP_DIV = 255;
    localparam logic [7:0] LEVEL_MAX = 8'hFF;

    localparam logic [10:0] FSW_FAST_KHZ = 11'h4B0;
    localparam logic [10:0] FSW_SLOW_KHZ = 11'h258;

    localparam logic [6:0] DRV_PCT_25  = 7'h19;
    localparam logic [6:0] DRV_PCT_50  = 7'h32;
    localparam logic [6:0] DRV_PCT_75  = 7'h4B;
    localparam logic [6:0] DRV_PCT_100 = 7'h64;

    localparam logic [12:0] VSC_MV_OFF = 13'h0000;
    localparam logic [12:0] VSC_MV_1   = 13'h0E10;
    localparam logic [12:0] VSC_MV_2   = 13'h12C0;
    localparam logic [12:0] VSC_MV_3   = 13'h16A8;

    typedef struct packed {
        logic [7:0]          cfg;
        logic [5:0]          chan_en;
        logic [5:0]          fault;
        logic [7:0]          phase;
        logic                pwm_q;
        logic                pwm_prev;
        logic [PERIOD_W-1:0] cnt;
        logic [PERIOD_W-1:0] period;
        logic [PERIOD_W-1:0] width;
        logic [5:0]          gate;
        logic [7:0]          dc_level;
        logic                dc_mode;
        logic [6:0]          drive_pct;
        logic [10:0]         freq_khz;
        logic                fsw_slow;
        logic                short_en;
        logic [12:0]         short_mv;
        logic [7:0]          rdata;
        logic                bl_on;
    } lcpc_state_t;
endpackage

// ==== lcpc_top.sv ====
`timescale 1ns/1ns
module lcpc_top (
    input  wire logic                clock_i,
    input  wire logic                resetn_i,
    input  wire logic                reg_wr_i,
    input  wire logic                reg_rd_i,
    input  wire logic [7:0]          reg_addr_i,
    input  wire logic [7:0]          reg_wdata_i,
    input  wire logic                dimming_pulse_input_i,
    input  wire logic [5:0]          channel_fault_i,
    input  wire logic                backlight_on_flag_i,
    output logic      [7:0]          reg_rdata_o,
    output logic      [5:0]          sink_gate_o,
    output logic                     duty_to_level_dimming_o,
    output logic      [7:0]          dc_level_o,
    output logic      [6:0]          boost_gate_drive_strength_o,
    output logic                     switching_freq_select_o,
    output logic      [10:0]         boost_freq_khz_o,
    output logic                     short_detect_en_o,
    output logic      [12:0]         short_threshold_mv_o,
    output logic                     backlight_o
);
    import lcpc_pkg::*;

    localparam int XW = PERIOD_W + 3;

    lcpc_state_t s_reg;
    lcpc_state_t s_next;

    logic [5:0]          active;
    logic [2:0]          n_active;
    logic [PERIOD_W-1:0] delay;
    logic [5:0]          gate_w;
    logic                direct_mode;
    logic                level_mode;
    logic [STEP_W-1:0]   step;
    logic [63:0]         step_wide;
    logic [63:0]         level_wide;
    logic [XW-1:0]       cycle_pos;

    assign active      = s_reg.chan_en & ~s_reg.fault;
    assign direct_mode = s_reg.cfg[CFG_DIRECT_BIT];
    assign level_mode  = s_reg.cfg[CFG_DC_BIT];
    assign step        = s_reg.phase[STEP_W-1:0];
    // position in the input period, zero in the cycle of the rising edge
    assign cycle_pos   = (s_reg.pwm_q & ~s_reg.pwm_prev) ? XW'(0)
                       : {3'h0, s_reg.cnt} + XW'(1);

    always_comb begin
        n_active = '0;
        for (int j = 0; j < NUM_CH; j++) begin
            n_active = n_active + 3'(active[j]);
        end
    end

    // per-channel delay, one step between neighbouring active channels, or the period over the active count when phase bit 7 is set and cfg bit 6 is clear
    always_comb begin
        step_wide = '0;
        delay     = '0;
        if (direct_mode) begin
            step_wide = (64'(step) * 64'(CLK_HZ)) / 64'(REF_HZ);
            delay     = PERIOD_W'(step_wide);
        end else if (s_reg.phase[PH_EQUAL_BIT]) begin
            if (n_active != 3'h0) begin
                delay = s_reg.period / PERIOD_W'(n_active);
            end
        end else begin
            step_wide = (64'(step) * 64'(s_reg.period)) / 64'(STEP_DIV);
            delay     = PERIOD_W'(step_wide);
        end
    end

    // each active channel replays the input pulse shifted by its rank in delays, or stays on in level mode
    genvar n;
    generate
        for (n = 0; n < NUM_CH; n++) begin : g_ch
            logic [2:0]    rank;
            logic [XW-1:0] offset;
            logic [XW-1:0] pos;
            logic          pulse;
            logic          gate_bit;
            always_comb begin
                rank = '0;
                for (int j = 0; j < n; j++) begin
                    rank = rank + 3'(active[j]);
                end
                offset = XW'({3'h0, delay} * XW'(rank));
                pos    = '0;
                pulse  = s_reg.pwm_q;
                if (offset != '0) begin
                    if (cycle_pos >= offset) begin
                        pos = cycle_pos - offset;
                    end else begin
                        pos = cycle_pos + {3'h0, s_reg.period} - offset;
                    end
                    pulse = pos < {3'h0, s_reg.width};
                end
                gate_bit = active[n] & (level_mode | pulse);
            end
            assign gate_w[n] = gate_bit;
        end
    endgenerate

    always_comb begin
        logic       rise;
        logic       fall;
        logic [5:0] en_new;
        rise       = 1'b0;
        fall       = 1'b0;
        en_new     = '0;
        level_wide = '0;
        s_next     = s_reg;

        s_next.pwm_q    = dimming_pulse_input_i;
        s_next.pwm_prev = s_reg.pwm_q;
        rise = s_reg.pwm_q & ~s_reg.pwm_prev;
        fall = ~s_reg.pwm_q & s_reg.pwm_prev;

        // input period and high time, counted from the rising edge
        if (rise) begin
            s_next.cnt = '0;
            if (s_reg.cnt != '1) begin
                s_next.period = s_reg.cnt + PERIOD_W'(1);
            end else begin
                s_next.period = s_reg.cnt;
            end
        end else if (s_reg.cnt != '1) begin
            s_next.cnt = s_reg.cnt + PERIOD_W'(1);
        end
        if (fall) begin
            if (s_reg.cnt != '1) begin
                s_next.width = s_reg.cnt + PERIOD_W'(1);
            end else begin
                s_next.width = s_reg.cnt;
            end
        end

        // register writes
        en_new = s_reg.chan_en;
        if (reg_wr_i) begin
            unique case (reg_addr_i)
                ADDR_CFG:   s_next.cfg = reg_wdata_i;
                ADDR_CHAN:  en_new = reg_wdata_i[5:0];
                ADDR_PHASE: s_next.phase = reg_wdata_i;
                default: ;
            endcase
        end
        s_next.chan_en = en_new;
        // a disabled bit clears its fault; disabling wins over a new fault in the same cycle
        s_next.fault = (s_reg.fault & en_new)
                     | (channel_fault_i & en_new);

        // register reads
        if (reg_rd_i) begin
            unique case (reg_addr_i)
                ADDR_CFG:   s_next.rdata = s_reg.cfg;
                ADDR_CHAN:  s_next.rdata = {2'h0, active};
                ADDR_PHASE: s_next.rdata = s_reg.phase;
                default:    s_next.rdata = '0;
            endcase
        end

        // configuration decode
        unique case (s_reg.cfg[CFG_DRV_LSB +: 2])
            2'h0: s_next.drive_pct = DRV_PCT_25;
            2'h1: s_next.drive_pct = DRV_PCT_50;
            2'h2: s_next.drive_pct = DRV_PCT_75;
            2'h3: s_next.drive_pct = DRV_PCT_100;
        endcase
        s_next.fsw_slow = s_reg.cfg[CFG_FSW_BIT];
        s_next.freq_khz = s_reg.cfg[CFG_FSW_BIT] ? FSW_SLOW_KHZ
                                                 : FSW_FAST_KHZ;
        unique case (s_reg.cfg[CFG_VSC_LSB +: 2])
            2'h0: s_next.short_mv = VSC_MV_OFF;
            2'h1: s_next.short_mv = VSC_MV_1;
            2'h2: s_next.short_mv = VSC_MV_2;
            2'h3: s_next.short_mv = VSC_MV_3;
        endcase
        s_next.short_en = s_reg.cfg[CFG_VSC_LSB +: 2] != 2'h0;

        // duty-to-level conversion of the last measured pulse
        s_next.dc_mode = level_mode;
        if (s_reg.period == '0) begin
            s_next.dc_level = s_reg.pwm_q ? LEVEL_MAX : 8'h00;
        end else begin
            level_wide = (64'(s_reg.width) * 64'(LEVEL_MAX))
                       / 64'(s_reg.period);
            if (level_wide > 64'(LEVEL_MAX)) begin
                s_next.dc_level = LEVEL_MAX;
            end else begin
                s_next.dc_level = 8'(level_wide);
            end
        end

        s_next.gate  = gate_w;
        s_next.bl_on = backlight_on_flag_i & (active != 6'h00);
    end

    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            s_reg           <= '0;
            s_reg.cfg       <= RST_CFG;
            s_reg.chan_en   <= RST_CHAN;
            s_reg.phase     <= RST_PHASE;
            s_reg.drive_pct <= DRV_PCT_100;
            s_reg.freq_khz  <= FSW_FAST_KHZ;
            s_reg.short_en  <= 1'b1;
            s_reg.short_mv  <= VSC_MV_3;
        end else begin
            s_reg <= s_next;
        end
    end

    assign reg_rdata_o                 = s_reg.rdata;
    assign sink_gate_o                 = s_reg.gate;
    assign duty_to_level_dimming_o     = s_reg.dc_mode;
    assign dc_level_o                  = s_reg.dc_level;
    assign boost_gate_drive_strength_o = s_reg.drive_pct;
    assign switching_freq_select_o     = s_reg.fsw_slow;
    assign boost_freq_khz_o            = s_reg.freq_khz;
    assign short_detect_en_o           = s_reg.short_en;
    assign short_threshold_mv_o        = s_reg.short_mv;
    assign backlight_o                 = s_reg.bl_on;
endmodule

// ==== lcpc_properties.sv ====
`timescale 1ns/1ns
module lcpc_properties
    import lcpc_pkg::*;
(
    input  wire logic        clock_i,
    input  wire logic        resetn_i,
    input  wire logic        reg_wr_i,
    input  wire logic        reg_rd_i,
    input  wire logic [7:0]  reg_addr_i,
    input  wire logic [7:0]  reg_wdata_i,
    input  wire logic [5:0]  channel_fault_i,
    input  wire logic        backlight_on_flag_i,
    input  wire logic [7:0]  reg_rdata_o,
    input  wire logic [5:0]  sink_gate_o,
    input  wire logic        duty_to_level_dimming_o,
    input  wire logic [6:0]  boost_gate_drive_strength_o,
    input  wire logic        switching_freq_select_o,
    input  wire logic [10:0] boost_freq_khz_o,
    input  wire logic        short_detect_en_o,
    input  wire logic [12:0] short_threshold_mv_o,
    input  wire logic        backlight_o
);
    localparam logic [6:0]  PCT [4] = '{DRV_PCT_25, DRV_PCT_50,
                                        DRV_PCT_75, DRV_PCT_100};
    localparam logic [12:0] MV [4]  = '{VSC_MV_OFF, VSC_MV_1,
                                        VSC_MV_2, VSC_MV_3};
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!resetn_i);
    logic cw;
    logic chw;
    assign cw = reg_wr_i && reg_addr_i == ADDR_CFG;
    assign chw = reg_wr_i && reg_addr_i == ADDR_CHAN;
    a_reset_decode: assert property ($rose(resetn_i) |->
        boost_gate_drive_strength_o == DRV_PCT_100
        && short_threshold_mv_o == VSC_MV_3)
        else $error("decoded outputs not at reset value");
    a_drive_map: assert property (cw ##2 1 |->
        boost_gate_drive_strength_o == PCT[$past(reg_wdata_i[4:3], 2)])
        else $error("drive strength decode wrong");
    a_freq_map: assert property (cw ##2 1 |->
        switching_freq_select_o == $past(reg_wdata_i[2], 2)
        && boost_freq_khz_o == (switching_freq_select_o ?
           FSW_SLOW_KHZ : FSW_FAST_KHZ))
        else $error("switching frequency decode wrong");
    a_short_map: assert property (cw ##2 1 |->
        short_threshold_mv_o == MV[$past(reg_wdata_i[1:0], 2)]
        && short_detect_en_o == ($past(reg_wdata_i[1:0], 2) != 2'h0))
        else $error("short threshold decode wrong");
    a_dc_mode_copy: assert property (cw ##2 1 |->
        duty_to_level_dimming_o == $past(reg_wdata_i[5], 2))
        else $error("level mode flag wrong");
    a_fault_readback: assert property (channel_fault_i != 6'h00 ##1
        reg_rd_i && reg_addr_i == ADDR_CHAN |=>
        (reg_rdata_o[5:0] & $past(channel_fault_i, 2)) == 6'h00)
        else $error("faulted channel reads as enabled");
    a_gate_disabled: assert property (chw |-> ##2
        (sink_gate_o & ~$past(reg_wdata_i[5:0], 2)) == 6'h00)
        else $error("disabled channel still gated");
    a_gate_fault: assert property (channel_fault_i != 6'h00 |-> ##2
        (sink_gate_o & $past(channel_fault_i, 2)) == 6'h00)
        else $error("faulted channel still gated");
    a_backlight_flag: assert property (!backlight_on_flag_i |=>
        !backlight_o)
        else $error("backlight on without status flag");
    c_cfg_write: cover property (cw);
    c_fault: cover property (channel_fault_i != 6'h00);
    c_backlight: cover property (backlight_o);
endmodule

bind lcpc_top lcpc_properties u_props (.*);

// ==== lcpc_pwm_host.sv ====
`timescale 1ns/1ns
module lcpc_pwm_host (
    input  wire logic       clock_i,
    input  wire logic [7:0] period_i,
    input  wire logic [7:0] high_i,
    output logic            pulse_o
);
    logic [7:0] cnt;
    initial begin
        cnt = 8'h00;
        pulse_o = 1'b0;
    end
    // pins move just after the falling edge, as the host's would
    always @(negedge clock_i) begin
        cnt <= (cnt + 8'h01 >= period_i) ? 8'h00 : cnt + 8'h01;
        pulse_o <= cnt < high_i;
    end
endmodule

// ==== tb_top.sv ====
`timescale 1ns/1ns
module tb_top;
    import lcpc_pkg::*;
    logic        clock_i = 1'b0;
    logic        resetn_i = 1'b0;
    logic        reg_wr_i = 1'b0;
    logic        reg_rd_i = 1'b0;
    logic [7:0]  reg_addr_i = 8'h00;
    logic [7:0]  reg_wdata_i = 8'h00;
    logic [5:0]  channel_fault_i = 6'h00;
    logic        backlight_on_flag_i = 1'b1;
    logic        dimming_pulse_input_i;
    logic [7:0]  per = 8'h78;
    logic [7:0]  hi = 8'h30;
    logic [7:0]  reg_rdata_o, dc_level_o;
    logic [5:0]  sink_gate_o;
    logic        duty_to_level_dimming_o, switching_freq_select_o;
    logic        short_detect_en_o, backlight_o;
    logic [6:0]  boost_gate_drive_strength_o;
    logic [10:0] boost_freq_khz_o;
    logic [12:0] short_threshold_mv_o;
    int          err_total = 0;
    int          check_count = 0;
    always #10 clock_i = ~clock_i;
    lcpc_top dut (.*);
    lcpc_pwm_host host (.clock_i(clock_i), .period_i(per), .high_i(hi),
                        .pulse_o(dimming_pulse_input_i));
    task automatic close_out();
        $display("checks=%0d mismatches=%0d", check_count, err_total);
        if (err_total == 0 && check_count > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    task automatic chk(input logic [12:0] got, input logic [12:0] exp);
        check_count++;
        if (got !== exp) begin
            err_total++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clock_i);
        {reg_wr_i, reg_addr_i, reg_wdata_i} = {1'b1, a, d};
        @(negedge clock_i);
        reg_wr_i = 1'b0;
    endtask
    task automatic rc(input logic [7:0] a, input logic [7:0] e);
        @(negedge clock_i);
        {reg_rd_i, reg_addr_i} = {1'b1, a};
        @(negedge clock_i);
        reg_rd_i = 1'b0;
        chk(reg_rdata_o, e);
    endtask
    task automatic meas(input int k, input int exp);
        int n;
        n = 0;
        repeat (300) @(negedge clock_i);
        while (sink_gate_o[0] !== 1'b0) @(negedge clock_i);
        while (sink_gate_o[0] !== 1'b1) @(negedge clock_i);
        while (sink_gate_o[k] !== 1'b1 && n < 1000) begin
            @(negedge clock_i);
            n++;
        end
        chk(13'(n), 13'(exp));
    endtask
    task automatic t_reset();
        rc(ADDR_CFG, 8'h1F);
        rc(ADDR_CHAN, 8'h3F);
        rc(ADDR_PHASE, 8'h00);
        rc(8'h0B, 8'h00);
        $display("test reset done");
    endtask
    task automatic t_cfg();
        logic [6:0]  pt [4] = '{7'h19, 7'h32, 7'h4B, 7'h64};
        logic [12:0] mt [4] = '{13'h0000, 13'h0E10, 13'h12C0, 13'h16A8};
        for (int i = 0; i < 4; i++) begin
            wr(ADDR_CFG, {3'h0, 2'(i), 1'(i), 2'(i)});
            @(negedge clock_i);
            chk(boost_gate_drive_strength_o, pt[i]);
            chk(boost_freq_khz_o, i[0] ? 11'h258 : 11'h4B0);
            chk(short_threshold_mv_o, mt[i]);
            chk(short_detect_en_o, i != 0);
            rc(ADDR_CFG, {3'h0, 2'(i), 1'(i), 2'(i)});
        end
        $display("test config done");
    endtask
    task automatic t_chan();
        wr(ADDR_CHAN, 8'h15);
        rc(ADDR_CHAN, 8'h15);
        wr(ADDR_CHAN, 8'h3F);
        channel_fault_i = 6'h04;
        rc(ADDR_CHAN, 8'h3B);
        channel_fault_i = 6'h00;
        chk(backlight_o, 1'b1);
        backlight_on_flag_i = 1'b0;
        @(negedge clock_i);
        chk(backlight_o, 1'b0);
        backlight_on_flag_i = 1'b1;
        wr(ADDR_CHAN, 8'h3B);
        wr(ADDR_CHAN, 8'h3F);
        rc(ADDR_CHAN, 8'h3F);
        wr(ADDR_CHAN, 8'h00);
        @(negedge clock_i);
        chk(backlight_o, 1'b0);
        wr(ADDR_CHAN, 8'h3F);
        $display("test channel done");
    endtask
    task automatic t_pwm();
        // every step below keeps first-to-last delay within one period
        wr(ADDR_CFG, 8'h1F);
        wr(ADDR_PHASE, 8'h80);
        meas(1, int'(per) / 6);
        wr(ADDR_PHASE, 8'h33);
        meas(1, int'(8'h33) * int'(per) / int'(STEP_DIV));
        wr(ADDR_CHAN, 8'h3D);
        meas(2, int'(8'h33) * int'(per) / int'(STEP_DIV));
        wr(ADDR_CFG, 8'h40);
        wr(ADDR_PHASE, 8'h04);
        meas(2, int'(4 * CLK_HZ / REF_HZ));
        $display("test phase done");
    endtask
    task automatic t_dc();
        wr(ADDR_CFG, 8'h3F);
        repeat (300) @(negedge clock_i);
        chk(sink_gate_o, 6'h3D);
        chk(dc_level_o, 13'(int'(hi) * int'(LEVEL_MAX) / int'(per)));
        $display("test level done");
    endtask
    initial begin
        repeat (5) @(negedge clock_i);
        resetn_i = 1'b1;
        t_reset();
        t_cfg();
        t_chan();
        t_pwm();
        t_dc();
        close_out();
    end
    initial begin
        #(20 * 20000);
        err_total++;
        close_out();
    end
endmodule
